// ===== hw/flow_sram_pkg.sv
// Constants and types shared by the flow-through burst SRAM access logic.
// Assumes one rising-edge clock and active-low asynchronous reset.

`default_nettype none

package flow_sram_pkg;

   // ------------------------------------------------------------------
   // Geometry
   // ------------------------------------------------------------------
   localparam int ADDR_W_DEFAULT = 18;
   localparam int BYTE_W         = 8;
   localparam int LANES          = 2;
   localparam int LANE_W         = BYTE_W + 1;
   localparam int WORD_W         = LANES * LANE_W;
   localparam int BURST_W        = 2;

   localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
   localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
   localparam logic [LANES-1:0]   LANE_ALL   = 2'h3;
   localparam logic [LANES-1:0]   LANE_NONE  = 2'h0;
   localparam logic               ORDER_INTERLEAVED = 1'h1;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   // Sleep entry and exit, in clock cycles; also the synchroniser depth
   localparam int SLEEP_TRANSITION_CYCLES = 2;
   localparam int SYNC_STAGES             = 2;

   typedef enum logic [1:0] {
      ACC_NONE,
      ACC_READ,
      ACC_WRITE
   } access_kind_t;

endpackage

`default_nettype wire

// ===== hw/burst_counter.sv
// Two-bit wraparound burst counter with linear or interleaved order.
// Assumes load and step come from logic on the same clock.

`default_nettype none

module burst_counter (
   input  wire logic                              clk,
   input  wire logic                              rst_n,
   input  wire logic                              load,
   input  wire logic [flow_sram_pkg::BURST_W-1:0] load_value,
   input  wire logic                              step,
   input  wire logic                              interleaved,
   output logic      [flow_sram_pkg::BURST_W-1:0] current_low,
   output logic      [flow_sram_pkg::BURST_W-1:0] next_low
);

   logic [flow_sram_pkg::BURST_W-1:0] start_reg;
   logic [flow_sram_pkg::BURST_W-1:0] offset_reg;
   logic [flow_sram_pkg::BURST_W-1:0] offset_next;

   function automatic logic [flow_sram_pkg::BURST_W-1:0] order_map(
      input logic [flow_sram_pkg::BURST_W-1:0] start,
      input logic [flow_sram_pkg::BURST_W-1:0] offs,
      input logic                              ilv);
      if (ilv) begin
         order_map = start ^ offs;
      end else begin
         order_map = start + offs;
      end
   endfunction

   assign offset_next = offset_reg + flow_sram_pkg::BURST_STEP;
   assign current_low = order_map(start_reg, offset_reg, interleaved);
   assign next_low    = order_map(start_reg, offset_next, interleaved);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         start_reg  <= flow_sram_pkg::BURST_ZERO;
         offset_reg <= flow_sram_pkg::BURST_ZERO;
      end else if (load) begin
         start_reg  <= load_value;
         offset_reg <= flow_sram_pkg::BURST_ZERO;
      end else if (step) begin
         // Two-bit offset wraps after the fourth beat
         offset_reg <= offset_next;
      end
   end

endmodule

`default_nettype wire

// ===== hw/flow_sram.sv
// Flow-through synchronous burst SRAM: access decode, storage and I/O.
// Assumes a controller on the same clock; output enable, sleep and the
// order strap are asynchronous and are synchronised here.

`default_nettype none

module flow_sram #(
   parameter int ADDR_W = flow_sram_pkg::ADDR_W_DEFAULT
) (
   input  wire logic                              clk,
   input  wire logic                              rst_n,
   input  wire logic [ADDR_W-1:0]                 address,
   input  wire logic                              chip_sel_primary_n,
   input  wire logic                              chip_sel_expand_hi,
   input  wire logic                              chip_sel_expand_n,
   input  wire logic                              proc_addr_strobe_n,
   input  wire logic                              ctrl_addr_strobe_n,
   input  wire logic                              burst_advance_n,
   input  wire logic                              global_write_n,
   input  wire logic                              byte_write_enable_n,
   input  wire logic [flow_sram_pkg::LANES-1:0]   byte_lane_select_n,
   input  wire logic                              output_enable_n,
   input  wire logic                              sleep_request,
   input  wire logic                              burst_order_mode,
   input  wire logic [flow_sram_pkg::LANES*flow_sram_pkg::BYTE_W-1:0]
                                                  data_in,
   output logic      [flow_sram_pkg::LANES*flow_sram_pkg::BYTE_W-1:0]
                                                  data_out,
   output logic                                   data_oe,
   input  wire logic [flow_sram_pkg::LANES-1:0]   parity_pins_in,
   output logic      [flow_sram_pkg::LANES-1:0]   parity_pins_out,
   output logic                                   parity_pins_oe
);

   localparam int DEPTH = 1 << ADDR_W;
   localparam int BW    = flow_sram_pkg::BYTE_W;
   localparam int LW    = flow_sram_pkg::LANE_W;
   localparam int LN    = flow_sram_pkg::LANES;
   localparam int SB    = flow_sram_pkg::BURST_W;

   initial begin
      if (ADDR_W < SB + 1 || ADDR_W > flow_sram_pkg::ADDR_W_DEFAULT) begin
         $error("flow_sram: ADDR_W out of range");
      end
   end

   // ------------------------------------------------------------------
   // Asynchronous inputs
   // ------------------------------------------------------------------
   // Two stages also give the two-cycle sleep entry and exit
   logic [flow_sram_pkg::SYNC_STAGES-1:0] sleep_sync_reg;
   logic [flow_sram_pkg::SYNC_STAGES-1:0] oe_sync_reg;
   logic [flow_sram_pkg::SYNC_STAGES-1:0] mode_sync_reg;
   logic                                  asleep;
   logic                                  oe_active;
   logic                                  interleaved;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sleep_sync_reg <= '0;
         oe_sync_reg    <= '0;
         mode_sync_reg  <= '1;
      end else begin
         sleep_sync_reg <= {sleep_sync_reg[flow_sram_pkg::SYNC_STAGES-2:0],
                            sleep_request};
         oe_sync_reg    <= {oe_sync_reg[flow_sram_pkg::SYNC_STAGES-2:0],
                            ~output_enable_n};
         mode_sync_reg  <= {mode_sync_reg[flow_sram_pkg::SYNC_STAGES-2:0],
                            burst_order_mode};
      end
   end

   assign asleep      = sleep_sync_reg[flow_sram_pkg::SYNC_STAGES-1];
   assign oe_active   = oe_sync_reg[flow_sram_pkg::SYNC_STAGES-1];
   assign interleaved = (mode_sync_reg[flow_sram_pkg::SYNC_STAGES-1] ==
                         flow_sram_pkg::ORDER_INTERLEAVED);

   // ------------------------------------------------------------------
   // Access decode at the clock edge
   // ------------------------------------------------------------------
   function automatic logic [LN-1:0] lanes_written(
      input logic          gw_n,
      input logic          bwe_n,
      input logic [LN-1:0] sel_n);
      if (!gw_n) begin
         lanes_written = flow_sram_pkg::LANE_ALL;
      end else if (!bwe_n) begin
         lanes_written = ~sel_n;
      end else begin
         lanes_written = flow_sram_pkg::LANE_NONE;
      end
   endfunction

   logic                       all_selected;
   logic                       proc_start;
   logic                       ctrl_start;
   logic                       deselect;
   logic                       write_request;
   logic [LN-1:0]              lane_we;
   logic                       burst_active_reg;
   logic [ADDR_W-1:SB]         base_reg;
   logic [SB-1:0]              cur_low;
   logic [SB-1:0]              nxt_low;
   logic                       advance;
   logic                       cont_cycle;
   flow_sram_pkg::access_kind_t access_kind;
   logic [ADDR_W-1:0]          access_addr;

   assign all_selected  = !chip_sel_primary_n && chip_sel_expand_hi &&
                          !chip_sel_expand_n;
   assign lane_we       = lanes_written(global_write_n, byte_write_enable_n,
                                        byte_lane_select_n);
   assign write_request = (lane_we != flow_sram_pkg::LANE_NONE);
   // Processor strobe counts only with primary select low
   assign proc_start    = !asleep && !proc_addr_strobe_n &&
                          !chip_sel_primary_n;
   assign ctrl_start    = !asleep && !proc_start && !ctrl_addr_strobe_n;
   assign deselect      = (proc_start || ctrl_start) && !all_selected;
   assign cont_cycle    = !asleep && !proc_start && ctrl_addr_strobe_n &&
                          burst_active_reg;
   assign advance       = cont_cycle && !burst_advance_n;

   always_comb begin
      access_kind = flow_sram_pkg::ACC_NONE;
      access_addr = {base_reg, cur_low};
      if (proc_start && all_selected) begin
         // Write controls ignored on this first cycle
         access_kind = flow_sram_pkg::ACC_READ;
         access_addr = address;
      end else if (ctrl_start && all_selected) begin
         access_kind = write_request ? flow_sram_pkg::ACC_WRITE
                                     : flow_sram_pkg::ACC_READ;
         access_addr = address;
      end else if (cont_cycle) begin
         access_kind = write_request ? flow_sram_pkg::ACC_WRITE
                                     : flow_sram_pkg::ACC_READ;
         if (advance) begin
            access_addr = {base_reg, nxt_low};
         end
      end
   end

   burst_counter u_burst (
      .clk         (clk),
      .rst_n       (rst_n),
      .load        ((proc_start || ctrl_start) && all_selected),
      .load_value  (address[SB-1:0]),
      .step        (advance),
      .interleaved (interleaved),
      .current_low (cur_low),
      .next_low    (nxt_low)
   );

   // ------------------------------------------------------------------
   // Burst state
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         burst_active_reg <= 1'b0;
         base_reg         <= '0;
      end else if (asleep || deselect) begin
         // Pending bursts are simply dropped on sleep
         burst_active_reg <= 1'b0;
      end else if ((proc_start || ctrl_start) && all_selected) begin
         burst_active_reg <= 1'b1;
         base_reg         <= address[ADDR_W-1:SB];
      end
   end

   // ------------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------------
   // No reset on the array: contents survive sleep and deselection
   logic [LW*LN-1:0] mem [DEPTH];
   logic [LW*LN-1:0] write_word;

   generate
      for (genvar g = 0; g < LN; g++) begin : g_lane
         assign write_word[g*LW +: LW] = {parity_pins_in[g],
                                          data_in[g*BW +: BW]};
      end
   endgenerate

   // One process owns the whole array; lanes are masked inside it
   always_ff @(posedge clk) begin
      if (access_kind == flow_sram_pkg::ACC_WRITE) begin
         for (int l = 0; l < LN; l++) begin
            if (lane_we[l]) begin
               mem[access_addr][l*LW +: LW] <= write_word[l*LW +: LW];
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // Read path and pin drive
   // ------------------------------------------------------------------
   logic             read_valid_reg;
   logic [LW*LN-1:0] read_word_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         read_valid_reg <= 1'b0;
         read_word_reg  <= '0;
      end else begin
         case (access_kind)
            flow_sram_pkg::ACC_READ: begin
               read_valid_reg <= 1'b1;
               read_word_reg  <= mem[access_addr];
            end
            flow_sram_pkg::ACC_WRITE: begin
               read_valid_reg <= 1'b0;
            end
            default: begin
               read_valid_reg <= 1'b0;
            end
         endcase
      end
   end

   generate
      for (genvar h = 0; h < LN; h++) begin : g_out
         assign data_out[h*BW +: BW] = read_word_reg[h*LW +: BW];
         assign parity_pins_out[h]   = read_word_reg[h*LW + BW];
      end
   endgenerate

   // Output enable is gated after its synchroniser, so it lags the pin
   assign data_oe        = read_valid_reg && oe_active && !asleep;
   assign parity_pins_oe = data_oe;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   chk_sleep_tristate: assert property (
      asleep |-> !data_oe && access_kind == flow_sram_pkg::ACC_NONE)
      else $error("pins driven or access taken while asleep");

   chk_write_tristate: assert property (
      access_kind == flow_sram_pkg::ACC_WRITE |=> !data_oe)
      else $error("data pins driven after a write");

   chk_proc_first_read: assert property (
      proc_start && all_selected && !global_write_n |->
         access_kind == flow_sram_pkg::ACC_READ && access_addr == address)
      else $error("processor strobe start was not a read");

   chk_strobe_priority: assert property (
      proc_start && !ctrl_addr_strobe_n |-> !ctrl_start)
      else $error("controller strobe acted over processor strobe");

   chk_ctrl_write_start: assert property (
      !asleep && proc_addr_strobe_n && !ctrl_addr_strobe_n &&
      all_selected && !global_write_n |->
         access_kind == flow_sram_pkg::ACC_WRITE &&
         access_addr == address)
      else $error("controller write not started");

   chk_deselect_drop: assert property (
      !asleep && !proc_addr_strobe_n && !chip_sel_primary_n &&
      !chip_sel_expand_hi |=> !burst_active_reg && !read_valid_reg)
      else $error("access survived deselection");

   chk_sleep_entry: assert property (
      sleep_request [*2] |=> asleep)
      else $error("sleep not entered after two cycles");

   chk_sleep_exit: assert property (
      !sleep_request [*2] |=> !asleep)
      else $error("sleep not left after two cycles");

   chk_burst_hold: assert property (
      cont_cycle && burst_advance_n |=>
         cur_low == $past(cur_low) && base_reg == $past(base_reg))
      else $error("burst address moved without advance");

   chk_read_drive: assert property (
      access_kind == flow_sram_pkg::ACC_READ && oe_sync_reg[0] &&
      !sleep_sync_reg[0] |=> data_oe)
      else $error("read data not driven after the edge");

   chk_linear_step: assert property (
      advance && !interleaved |->
         access_addr[SB-1:0] == cur_low + flow_sram_pkg::BURST_STEP)
      else $error("linear burst step wrong");

   chk_global_all: assert property (
      !global_write_n |-> lane_we == flow_sram_pkg::LANE_ALL)
      else $error("global write missed a lane");

   cov_ctrl_write: cover property (
      ctrl_start && access_kind == flow_sram_pkg::ACC_WRITE);
   cov_proc_then_write: cover property (
      proc_start && all_selected ##1
      access_kind == flow_sram_pkg::ACC_WRITE);
   cov_full_burst: cover property (
      advance [*3]);
   cov_sleep_cycle: cover property (
      !asleep ##1 asleep [*2] ##1 !asleep);

endmodule

`default_nettype wire

// ===== sim/sram_ctrl_model.sv
// Controller model: drives selects, strobes, write controls and data.
// Assumes the bench calls its tasks just after a rising clock edge.

`default_nettype none

module sram_ctrl_model #(
   parameter int AW = 6
) (
   input  wire logic          clk,
   output logic      [AW-1:0] address,
   output logic               chip_sel_primary_n,
   output logic               chip_sel_expand_hi,
   output logic               chip_sel_expand_n,
   output logic               proc_addr_strobe_n,
   output logic               ctrl_addr_strobe_n,
   output logic               burst_advance_n,
   output logic               global_write_n,
   output logic               byte_write_enable_n,
   output logic      [1:0]    byte_lane_select_n,
   output logic               output_enable_n,
   output logic               sleep_request,
   output logic      [15:0]   data_in,
   output logic      [1:0]    parity_pins_in
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      {chip_sel_primary_n, chip_sel_expand_hi, chip_sel_expand_n} = 3'h5;
      {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n} = 3'h7;
      {global_write_n, byte_write_enable_n, byte_lane_select_n} = 4'hf;
      address = '0;
      {parity_pins_in, data_in} = 18'h0;
      output_enable_n = 1'b0;
      sleep_request = 1'b0;
   end

   // One bus cycle: drive now, return just after the sampling edge
   task automatic cyc(input logic [2:0] cs, input logic [2:0] strb,
                      input logic [3:0] wr, input logic [AW-1:0] a,
                      input logic [17:0] wd);
      {chip_sel_primary_n, chip_sel_expand_hi, chip_sel_expand_n} = cs;
      {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n} = strb;
      {global_write_n, byte_write_enable_n, byte_lane_select_n} = wr;
      address = a;
      if (!wr[3] || (!wr[2] && wr[1:0] != 2'h3))
         {parity_pins_in, data_in} = wd;
      else
         // Released bus: never leave a stale value that could pass
         {parity_pins_in, data_in} = ~{parity_pins_in, data_in};
      @(posedge clk);
      #1;
   endtask

   task automatic idle(input int n);
      for (int i = 0; i < n; i++)
         cyc(3'h5, 3'h7, 4'hf, ~address, 18'h0);
   endtask

   task automatic set_oe(input logic v);
      output_enable_n = v;
      idle(3);
   endtask

   task automatic set_sleep(input logic v);
      idle(1);
      sleep_request = v;
      idle(3);
   endtask
endmodule

`default_nettype wire

// ===== sim/flow_through_burst_sram_access_tb_top.sv
// Self-checking bench for the flow-through burst SRAM access logic.
// Assumes flow_sram_pkg and sram_ctrl_model are compiled first.

`default_nettype none

module flow_through_burst_sram_access_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int AW = 6;
   localparam logic [2:0] SEL = 3'h2;
   localparam logic [2:0] CTRL = 3'h5;
   localparam logic [2:0] BOTH = 3'h1;
   localparam logic [2:0] BURST_ADVANCE_N = 3'h6;
   localparam logic [2:0] NONE = 3'h7;
   localparam logic [3:0] RD = 4'hf;
   localparam logic [3:0] GW = 4'h7;

   logic          clk, rst_n, burst_order_mode;
   logic [AW-1:0] address;
   logic          cs1_n, cs2, cs3_n, ps_n, cs_n, adv_n, gw_n, bwe_n, oe_n;
   logic          sleep_request, data_oe, parity_pins_oe;
   logic [1:0]    sel_n, parity_pins_in, parity_pins_out;
   logic [15:0]   data_in, data_out;
   logic [17:0]   rd_word;
   logic [17:0]   exp_mem [64];
   int            num_errors, tests_run;

   assign rd_word = {parity_pins_out, data_out};

   sram_ctrl_model #(.AW(AW)) m (
      .clk(clk), .address(address), .chip_sel_primary_n(cs1_n),
      .chip_sel_expand_hi(cs2), .chip_sel_expand_n(cs3_n),
      .proc_addr_strobe_n(ps_n), .ctrl_addr_strobe_n(cs_n),
      .burst_advance_n(adv_n), .global_write_n(gw_n),
      .byte_write_enable_n(bwe_n), .byte_lane_select_n(sel_n),
      .output_enable_n(oe_n), .sleep_request(sleep_request),
      .data_in(data_in), .parity_pins_in(parity_pins_in));

   flow_sram #(.ADDR_W(AW)) dut (
      .clk(clk), .rst_n(rst_n), .address(address),
      .chip_sel_primary_n(cs1_n), .chip_sel_expand_hi(cs2),
      .chip_sel_expand_n(cs3_n), .proc_addr_strobe_n(ps_n),
      .ctrl_addr_strobe_n(cs_n), .burst_advance_n(adv_n),
      .global_write_n(gw_n), .byte_write_enable_n(bwe_n),
      .byte_lane_select_n(sel_n), .output_enable_n(oe_n),
      .sleep_request(sleep_request), .burst_order_mode(burst_order_mode),
      .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
      .parity_pins_in(parity_pins_in), .parity_pins_out(parity_pins_out),
      .parity_pins_oe(parity_pins_oe));

   // ------------------------------------------------------------------
   // Checks and shared cycles
   // ------------------------------------------------------------------
   task automatic check_word(input string what, input logic [17:0] exp,
                             input logic [17:0] got);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic check_bit(input string what, input logic exp,
                            input logic got);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic do_read(input logic [AW-1:0] a);
      m.cyc(SEL, CTRL, RD, a, 18'h0);
      check_bit("read_oe", 1'b1, data_oe & parity_pins_oe);
      check_word("read_data", exp_mem[a], rd_word);
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic preload;
      m.set_oe(1'b1);
      for (int a = 0; a < 64; a++) begin
         exp_mem[a] = {2'(a), 8'(a), ~8'(a)};
         m.cyc(SEL, CTRL, GW, AW'(a), exp_mem[a]);
      end
      m.set_oe(1'b0);
      for (int a = 0; a < 64; a += 9)
         do_read(AW'(a));
      $display("test preload done");
   endtask

   task automatic t_burst(input logic mode);
      logic [AW-1:0] base;
      logic [1:0]    lo;
      burst_order_mode = mode;
      m.idle(3);
      for (int s = 0; s < 4; s++) begin
         base = AW'(8 + s);
         m.cyc(SEL, CTRL, RD, base, 18'h0);
         check_word("burst_first", exp_mem[base], rd_word);
         for (int k = 1; k < 5; k++) begin
            lo = mode ? 2'(s) ^ 2'(k) : 2'(s + k);
            // Upper bits driven wrong: the held address must be used
            m.cyc(SEL, BURST_ADVANCE_N, RD, ~base, 18'h0);
            check_word("burst_next", exp_mem[{base[5:2], lo}], rd_word);
         end
         m.cyc(SEL, NONE, RD, ~base, 18'h0);
         check_word("burst_hold", exp_mem[{base[5:2], lo}], rd_word);
      end
      $display("test burst mode %b done", mode);
   endtask

   task automatic t_proc_write;
      logic [17:0] d;
      d = 18'h2_5a3c;
      m.cyc(SEL, BOTH, GW, 6'h11, d);
      check_bit("proc_start_oe", 1'b1, data_oe);
      check_word("proc_start", exp_mem[6'h11], rd_word);
      m.cyc(SEL, NONE, RD, 6'h2e, 18'h0);
      check_word("proc_hold", exp_mem[6'h11], rd_word);
      // Output enable left low on purpose: the write must tristate anyway
      m.cyc(SEL, NONE, GW, 6'h2e, d);
      check_bit("proc_write_oe", 1'b0, data_oe);
      exp_mem[6'h11] = d;
      do_read(6'h11);
      $display("test proc_write done");
   endtask

   task automatic t_byte_write;
      logic [3:0]  wr [5] = '{4'ha, 4'h9, 4'hb, 4'hc, 4'h3};
      logic [17:0] mk [5] = '{18'h1_00ff, 18'h2_ff00, 18'h0, 18'h0,
                              18'h3_ffff};
      logic [17:0] d;
      for (int i = 0; i < 5; i++) begin
         d = {~2'(i), 8'(8'h70 + i), 8'(8'h90 + i)};
         m.cyc(SEL, CTRL, wr[i], 6'h22, d);
         if (mk[i] == 18'h0)
            check_word("byte_none", exp_mem[6'h22], rd_word);
         else
            check_bit("byte_write_oe", 1'b0, data_oe);
         exp_mem[6'h22] = (exp_mem[6'h22] & ~mk[i]) | (d & mk[i]);
         do_read(6'h22);
      end
      $display("test byte_write done");
   endtask

   task automatic t_deselect;
      m.cyc(3'h0, BOTH, GW, 6'h30, 18'h0_1234);
      check_bit("desel_oe", 1'b0, data_oe);
      m.cyc(3'h6, NONE, GW, 6'h30, 18'h0_1234);
      check_bit("no_burst_oe", 1'b0, data_oe);
      do_read(6'h30);
      // Ignored processor strobe must leave the burst running
      m.cyc(3'h6, 3'h3, RD, 6'h0f, 18'h0);
      check_bit("proc_ignored_oe", 1'b1, data_oe);
      check_word("proc_ignored", exp_mem[6'h30], rd_word);
      m.cyc(3'h3, CTRL, RD, 6'h0f, 18'h0);
      check_bit("expand_desel_oe", 1'b0, data_oe);
      $display("test deselect done");
   endtask

   task automatic t_sleep;
      m.set_sleep(1'b1);
      m.cyc(SEL, CTRL, RD, 6'h05, 18'h0);
      check_bit("sleep_read_oe", 1'b0, data_oe);
      m.cyc(SEL, CTRL, GW, 6'h05, 18'h3_0f0f);
      m.set_sleep(1'b0);
      do_read(6'h05);
      $display("test sleep done");
   endtask

   // ------------------------------------------------------------------
   // Clock, reset, sequence and watchdog
   // ------------------------------------------------------------------
   always #20 clk = ~clk;

   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      burst_order_mode = 1'b1;
      num_errors = 0;
      tests_run = 0;
      repeat (6) @(posedge clk);
      #1;
      rst_n = 1'b1;
      m.idle(3);
      preload();
      t_burst(1'b1);
      t_burst(1'b0);
      t_proc_write();
      t_byte_write();
      t_deselect();
      t_sleep();
      give_verdict();
   end

   // About 170 cycles expected; over twenty times that means a hang
   initial begin
      #160000;
      num_errors++;
      give_verdict();
   end
endmodule

`default_nettype wire
